// ===== hps_sequencer.v
/*
  Host port compound state-change sequencer with an AHB-Lite register slave
  and a masked, read-to-clear event interrupt.
  Assumes one AHB-Lite master, single word transfers, and port event inputs
  synchronous to CLK_I.
*/
// Operation
// - After the write, hardware runs every remaining step alone until done.
// - Wait-attach-then-disabled first waits for attach, then sets connect flag.
// - Attach detection in a wait compound starts disabled-state processing.
// - Disabled processing end sets disabled-complete; wait-then-disabled ends there.
// - Wait-then-operational starts bus reset right after disabled-complete.
// - High-speed device: chirp seen during reset sets chirp-normal before reset complete.
// - Full or low speed: no chirp, neither chirp flag is set.
// - End of reset phase sets the reset-complete flag.
// - With reset-complete, operational processing starts; sequence ends operational.
// - Reset-then-operational begins bus reset at time zero, then reports as above.
// - Each phase keeps the single-command timing, no added or removed delay.
// - Disconnect, VBUS error or chirp error aborts the sequence to error handling; in the wait phase only VBUS error does.
// - State monitor shows each phase in turn, changing as flags rise.
`timescale 1ns/1ps
`default_nettype none
`include "hps_regs.vh"

module hps_sequencer #(
  parameter DIS_TIME_US = `HPS_DIS_TIME_US,
  parameter RST_TIME_US = `HPS_RST_TIME_US,
  parameter DIS_CYCLES = DIS_TIME_US * `HPS_NS_PER_US / `HPS_CLK_PERIOD_NS,
  parameter RST_CYCLES = RST_TIME_US * `HPS_NS_PER_US / `HPS_CLK_PERIOD_NS
) (
  input wire CLK_I, // Controller clock, 10 MHz
  input wire RST_I, // Synchronous reset, active high
  input wire HSEL_I, // AHB slave select
  input wire [31:0] HADDR_I, // AHB address
  input wire [1:0] HTRANS_I, // AHB transfer type
  input wire HWRITE_I, // AHB write
  input wire [2:0] HSIZE_I, // AHB size, word only
  input wire [31:0] HWDATA_I, // AHB write data
  input wire HREADY_I, // AHB bus ready
  output wire HREADYOUT_O, // AHB slave ready, never stalls
  output wire HRESP_O, // AHB response, always OKAY
  output reg [31:0] HRDATA_O, // AHB read data
  input wire ATTACH_I, // Device attachment seen on the port
  input wire CHIRP_OK_I, // Downstream device chirp detected
  input wire CHIRP_NG_I, // Downstream device chirp error
  input wire DISCONNECT_I, // Device removed
  input wire VBUS_ERR_I, // VBUS fault
  output wire [2:0] STATE_O, // Host state monitor
  output reg BUS_RESET_O, // Drive bus reset on the port
  output reg PORT_OP_O, // Port in normal operation
  output reg IRQ_O // Level interrupt
);

  localparam [`HPS_TMR_W-1:0] DIS_CNT = DIS_CYCLES[`HPS_TMR_W-1:0];
  localparam [`HPS_TMR_W-1:0] RST_CNT = RST_CYCLES[`HPS_TMR_W-1:0];

  reg [3:0] cmd_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [2:0] goal_r;
  reg [2:0] goal_nxt;
  reg [`HPS_EV0_W-1:0] ev0_r;
  reg [`HPS_EV1_W-1:0] ev1_r;
  reg [`HPS_EV0_W-1:0] mask0_r;
  reg [`HPS_EV1_W-1:0] mask1_r;
  reg [`HPS_EV0_W-1:0] set0;
  reg [`HPS_EV1_W-1:0] set1;
  reg chirp_seen_r;
  reg chirp_seen_nxt;
  reg tmr_load;
  reg [`HPS_TMR_W-1:0] tmr_count;
  reg tmr_stop;
  wire tmr_busy;
  wire tmr_done;

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  reg wr_pend_r;
  reg [`HPS_ADDR_MSB:0] wr_addr_r;
  wire acc = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire rd_acc = acc & ~HWRITE_I;
  wire [`HPS_ADDR_MSB:0] a_ofs = {HADDR_I[`HPS_ADDR_MSB:`HPS_ADDR_LSB], 2'b00};
  wire clr0 = rd_acc & (a_ofs == `HPS_OFS_STAT0);
  wire clr1 = rd_acc & (a_ofs == `HPS_OFS_STAT1);
  wire wr_ctrl = wr_pend_r & (wr_addr_r == `HPS_OFS_CTRL);
  wire [3:0] wr_cmd = HWDATA_I[`HPS_CMD_MSB:`HPS_CMD_LSB];
  wire busy = (goal_r != state_r) | tmr_busy;

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign STATE_O = state_r;

  function [31:0] rd_mux;
    input [`HPS_ADDR_MSB:0] ofs;
    begin
      case (ofs)
        `HPS_OFS_CTRL: rd_mux = {19'h00000, busy, 1'b0, state_r, 4'h0, cmd_r};
        `HPS_OFS_STAT0: rd_mux = {27'h0000000, ev0_r};
        `HPS_OFS_STAT1: rd_mux = {30'h00000000, ev1_r};
        `HPS_OFS_MASK0: rd_mux = {27'h0000000, mask0_r};
        `HPS_OFS_MASK1: rd_mux = {30'h00000000, mask1_r};
        default: rd_mux = 32'h00000000;
      endcase
    end
  endfunction

  always @(posedge CLK_I) begin
    if (RST_I) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= {(`HPS_ADDR_MSB+1){1'b0}};
      HRDATA_O <= 32'h00000000;
      mask0_r <= `HPS_MASK0_RESET;
      mask1_r <= `HPS_MASK1_RESET;
    end else begin
      wr_pend_r <= acc & HWRITE_I;
      if (acc) begin
        wr_addr_r <= a_ofs;
      end
      if (rd_acc) begin
        HRDATA_O <= rd_mux(a_ofs);
      end
      if (wr_pend_r & (wr_addr_r == `HPS_OFS_MASK0)) begin
        mask0_r <= HWDATA_I[`HPS_EV0_W-1:0];
      end
      if (wr_pend_r & (wr_addr_r == `HPS_OFS_MASK1)) begin
        mask1_r <= HWDATA_I[`HPS_EV1_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase timer; phases use the plain single-command lengths unchanged

  hps_phase_timer #(
    .W(`HPS_TMR_W)
  ) u_timer (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .load_i(tmr_load),
    .stop_i(tmr_stop),
    .count_i(tmr_count),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always @* begin
    state_nxt = state_r;
    goal_nxt = goal_r;
    chirp_seen_nxt = chirp_seen_r;
    set0 = {`HPS_EV0_W{1'b0}};
    set1 = {`HPS_EV1_W{1'b0}};
    tmr_load = 1'b0;
    tmr_stop = 1'b0;
    tmr_count = DIS_CNT;
    if (wr_ctrl) begin
      // A write is time zero; the first phase starts in the same edge
      chirp_seen_nxt = 1'b0;
      case (wr_cmd)
        `HPS_CMD_WAIT, `HPS_CMD_WAIT_DIS, `HPS_CMD_WAIT_OP: begin
          state_nxt = `HPS_ST_WAIT;
          tmr_stop = 1'b1;
          goal_nxt = (wr_cmd == `HPS_CMD_WAIT) ? `HPS_ST_WAIT :
                     (wr_cmd == `HPS_CMD_WAIT_DIS) ? `HPS_ST_DIS : `HPS_ST_OP;
        end
        `HPS_CMD_DIS: begin
          state_nxt = `HPS_ST_DIS;
          goal_nxt = `HPS_ST_DIS;
          tmr_load = 1'b1;
        end
        `HPS_CMD_RST, `HPS_CMD_RST_OP: begin
          state_nxt = `HPS_ST_RST;
          goal_nxt = (wr_cmd == `HPS_CMD_RST) ? `HPS_ST_RST : `HPS_ST_OP;
          tmr_load = 1'b1;
          tmr_count = RST_CNT;
        end
        `HPS_CMD_OP: begin
          state_nxt = `HPS_ST_OP;
          goal_nxt = `HPS_ST_OP;
          tmr_stop = 1'b1;
        end
        default: begin
        end
      endcase
    end else if ((DISCONNECT_I | VBUS_ERR_I | CHIRP_NG_I) &&
                 state_r != `HPS_ST_IDLE && state_r != `HPS_ST_WAIT) begin
      // Abort to idle; firmware runs its own recovery from there
      state_nxt = `HPS_ST_IDLE;
      goal_nxt = `HPS_ST_IDLE;
      tmr_stop = 1'b1;
    end else if (VBUS_ERR_I && state_r == `HPS_ST_WAIT) begin
      state_nxt = `HPS_ST_IDLE;
      goal_nxt = `HPS_ST_IDLE;
    end else begin
      case (state_r)
        `HPS_ST_WAIT: begin
          if (ATTACH_I) begin
            set0[`HPS_EV0_CONNECT] = 1'b1;
            if (goal_r != `HPS_ST_WAIT) begin
              state_nxt = `HPS_ST_DIS;
              tmr_load = 1'b1;
              tmr_count = DIS_CNT;
            end
          end
        end
        `HPS_ST_DIS: begin
          if (tmr_done) begin
            set1[`HPS_EV1_DIS_CMP] = 1'b1;
            if (goal_r == `HPS_ST_OP) begin
              state_nxt = `HPS_ST_RST;
              tmr_load = 1'b1;
              tmr_count = RST_CNT;
            end
          end
        end
        `HPS_ST_RST: begin
          if (tmr_busy && CHIRP_OK_I && !chirp_seen_r) begin
            set0[`HPS_EV0_CHIRP_OK] = 1'b1;
            chirp_seen_nxt = 1'b1;
          end
          // No chirp input from a full or low speed device: no chirp flag
          if (tmr_done) begin
            set1[`HPS_EV1_RST_CMP] = 1'b1;
            if (goal_r == `HPS_ST_OP) begin
              state_nxt = `HPS_ST_OP;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (CHIRP_NG_I && state_r == `HPS_ST_RST) begin
      set0[`HPS_EV0_CHIRP_NG] = 1'b1;
    end
    if (DISCONNECT_I) begin
      set0[`HPS_EV0_DISCONNECT] = 1'b1;
    end
    if (VBUS_ERR_I) begin
      set0[`HPS_EV0_VBUS_ERR] = 1'b1;
    end
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      cmd_r <= `HPS_CMD_NONE;
      state_r <= `HPS_ST_IDLE;
      goal_r <= `HPS_ST_IDLE;
      chirp_seen_r <= 1'b0;
      ev0_r <= `HPS_EV0_RESET;
      ev1_r <= `HPS_EV1_RESET;
      BUS_RESET_O <= 1'b0;
      PORT_OP_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        cmd_r <= wr_cmd;
      end
      state_r <= state_nxt;
      goal_r <= goal_nxt;
      chirp_seen_r <= chirp_seen_nxt;
      // A new event wins over the clear made by a status read
      ev0_r <= (ev0_r & ~{`HPS_EV0_W{clr0}}) | set0;
      ev1_r <= (ev1_r & ~{`HPS_EV1_W{clr1}}) | set1;
      BUS_RESET_O <= (state_nxt == `HPS_ST_RST) & (tmr_load | (tmr_busy & ~tmr_done));
      PORT_OP_O <= (state_nxt == `HPS_ST_OP);
      IRQ_O <= |(((ev0_r & ~{`HPS_EV0_W{clr0}}) | set0) & mask0_r) |
               |(((ev1_r & ~{`HPS_EV1_W{clr1}}) | set1) & mask1_r);
    end
  end

endmodule // hps_sequencer

`default_nettype wire

// ===== hps_regs.vh
/*
  Constants for the host port compound sequencer: register offsets, field
  positions, command codes, state monitor codes and timing figures.
  Assumes inclusion by bare name from the design files.
*/
`ifndef HPS_REGS_VH
`define HPS_REGS_VH

// Byte offsets on the register bus
`define HPS_OFS_CTRL 8'h00
`define HPS_OFS_STAT0 8'h04
`define HPS_OFS_STAT1 8'h08
`define HPS_OFS_MASK0 8'h0C
`define HPS_OFS_MASK1 8'h10
`define HPS_ADDR_LSB 2
`define HPS_ADDR_MSB 7

// Control word fields
`define HPS_CMD_MSB 3
`define HPS_CMD_LSB 0
`define HPS_MON_MSB 10
`define HPS_MON_LSB 8
`define HPS_BUSY_BIT 12

// Command codes
`define HPS_CMD_NONE 4'h0
`define HPS_CMD_WAIT 4'h1
`define HPS_CMD_DIS 4'h2
`define HPS_CMD_RST 4'h3
`define HPS_CMD_OP 4'h4
`define HPS_CMD_WAIT_DIS 4'h5
`define HPS_CMD_WAIT_OP 4'h6
`define HPS_CMD_RST_OP 4'h7

// State monitor codes
`define HPS_ST_IDLE 3'h0
`define HPS_ST_WAIT 3'h1
`define HPS_ST_DIS 3'h2
`define HPS_ST_RST 3'h3
`define HPS_ST_OP 3'h4

// First event status: bit positions
`define HPS_EV0_CONNECT 0
`define HPS_EV0_CHIRP_OK 1
`define HPS_EV0_CHIRP_NG 2
`define HPS_EV0_DISCONNECT 3
`define HPS_EV0_VBUS_ERR 4
`define HPS_EV0_W 5
// Second event status: bit positions
`define HPS_EV1_DIS_CMP 0
`define HPS_EV1_RST_CMP 1
`define HPS_EV1_W 2

`define HPS_EV0_RESET 5'h00
`define HPS_EV1_RESET 2'h0
`define HPS_MASK0_RESET 5'h00
`define HPS_MASK1_RESET 2'h0

// Timing
`define HPS_CLK_PERIOD_NS 100
`define HPS_NS_PER_US 1000
`define HPS_DIS_TIME_US 2
`define HPS_RST_TIME_US 10000
`define HPS_TMR_W 24

`endif

// ===== hps_phase_timer.v
/*
  Phase timer of the compound sequencer: loads a cycle count and gives a
  one-cycle done pulse when it runs out.
  Assumes a count of at least one and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hps_regs.vh"

module hps_phase_timer #(
  parameter W = `HPS_TMR_W
) (
  input wire clk_i, // Clock
  input wire rst_i, // Synchronous reset
  input wire load_i, // Start a new phase
  input wire stop_i, // Abandon the running phase
  input wire [W-1:0] count_i, // Phase length in cycles
  output wire busy_o, // Phase running
  output reg done_o // One-cycle pulse at phase end
);

  reg [W-1:0] cnt_r;
  reg run_r;

  assign busy_o = run_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= {W{1'b0}};
      run_r <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i) begin
        cnt_r <= count_i;
        run_r <= 1'b1;
      end else if (stop_i) begin
        run_r <= 1'b0;
      end else if (run_r) begin
        if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
          run_r <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // hps_phase_timer

`default_nettype wire

// ===== hps_usb_device_model.sv
/* Downstream USB device model: attach level and high-speed chirp.
   Assumes the port's bus reset output and the controller clock. */
`timescale 1ns/1ps
`default_nettype none
module hps_usb_device_model (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic plugged_i, // Cable present
  input wire logic high_speed_i, // Device runs high speed
  input wire logic bus_reset_i, // Host drives bus reset
  output logic attach_o, // Attach seen by host
  output logic chirp_o // Device chirp
);
  logic [3:0] cnt_r;
  always @(posedge clk_i) begin
    if (rst_i || !bus_reset_i)
      cnt_r <= 4'h0;
    else if (cnt_r != 4'hF)
      cnt_r <= cnt_r + 4'h1;
  end
  assign attach_o = plugged_i;
  // A device needs some reset time before it answers, so the chirp comes late
  assign chirp_o = high_speed_i && bus_reset_i && cnt_r >= 4'h3 && cnt_r < 4'h5;
endmodule // hps_usb_device_model
`default_nettype wire

// ===== hps_sequencer_monitor.sv
/* Port checker for the compound sequencer.
   Assumes binding onto hps_sequencer; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
`include "hps_regs.vh"
module hps_sequencer_monitor #(
  parameter DIS_CYCLES = 5,
  parameter RST_CYCLES = 12
) (
  input wire logic CLK_I, // Clock
  input wire logic RST_I, // Reset
  input wire logic HSEL_I, // Select
  input wire logic [1:0] HTRANS_I, // Transfer type
  input wire logic HWRITE_I, // Write
  input wire logic HREADY_I, // Bus ready
  input wire logic ATTACH_I, // Attach
  input wire logic CHIRP_NG_I, // Chirp error
  input wire logic DISCONNECT_I, // Removal
  input wire logic VBUS_ERR_I, // VBUS fault
  input wire logic [2:0] STATE_O, // State monitor
  input wire logic BUS_RESET_O, // Bus reset drive
  input wire logic PORT_OP_O // Operational
);
  logic wr_r;
  // Phase counters as wide as the phase timer, so full-length phases fit
  logic [`HPS_TMR_W-1:0] dis_cnt_r;
  logic [`HPS_TMR_W-1:0] rst_cnt_r;
  wire err = CHIRP_NG_I | DISCONNECT_I | VBUS_ERR_I;
  ////////////////////////////////////////
  // A write landing at the next edge may redirect the state legally
  always @(posedge CLK_I) begin
    if (RST_I) begin
      wr_r <= 1'b0;
      dis_cnt_r <= '0;
      rst_cnt_r <= '0;
    end else begin
      wr_r <= HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I;
      dis_cnt_r <= (STATE_O == `HPS_ST_DIS) ? dis_cnt_r + 1'b1 : '0;
      rst_cnt_r <= (STATE_O == `HPS_ST_RST) ? rst_cnt_r + 1'b1 : '0;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  ////////////////////////////////////////
  a_wait_holds: assert property ((STATE_O == `HPS_ST_WAIT && !ATTACH_I && !VBUS_ERR_I && !wr_r)
    |=> STATE_O == `HPS_ST_WAIT) else $error("left wait without attach");
  a_attach_to_dis: assert property ((STATE_O == `HPS_ST_DIS && $past(STATE_O) == `HPS_ST_WAIT
    && !$past(wr_r)) |-> $past(ATTACH_I)) else $error("disabled entered without attach");
  a_dis_span: assert property ((STATE_O == `HPS_ST_RST && $past(STATE_O) == `HPS_ST_DIS
    && !$past(wr_r)) |-> dis_cnt_r == DIS_CYCLES + 1) else $error("disabled phase length");
  a_rst_span: assert property ((STATE_O == `HPS_ST_OP && $past(STATE_O) == `HPS_ST_RST
    && !$past(wr_r)) |-> rst_cnt_r == RST_CYCLES + 1) else $error("reset phase length");
  a_rst_entry: assert property ((STATE_O == `HPS_ST_RST && $past(STATE_O) != `HPS_ST_RST
    && !$past(wr_r)) |-> $past(STATE_O) == `HPS_ST_DIS) else $error("reset out of order");
  a_op_entry: assert property ((STATE_O == `HPS_ST_OP && $past(STATE_O) != `HPS_ST_OP
    && !$past(wr_r)) |-> $past(STATE_O) == `HPS_ST_RST) else $error("operational out of order");
  a_op_flag: assert property (PORT_OP_O == (STATE_O == `HPS_ST_OP))
    else $error("operational output mismatch");
  a_reset_drive: assert property (BUS_RESET_O |-> STATE_O == `HPS_ST_RST)
    else $error("bus reset outside reset state");
  a_error_abort: assert property ((err && !wr_r && (STATE_O == `HPS_ST_DIS
    || STATE_O == `HPS_ST_RST || STATE_O == `HPS_ST_OP)) |=> STATE_O == `HPS_ST_IDLE)
    else $error("error did not abort");
endmodule // hps_sequencer_monitor
bind hps_sequencer hps_sequencer_monitor #(.DIS_CYCLES(DIS_CYCLES), .RST_CYCLES(RST_CYCLES)) u_mon (
  .CLK_I(CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
  .HREADY_I(HREADY_I), .ATTACH_I(ATTACH_I), .CHIRP_NG_I(CHIRP_NG_I),
  .DISCONNECT_I(DISCONNECT_I), .VBUS_ERR_I(VBUS_ERR_I), .STATE_O(STATE_O),
  .BUS_RESET_O(BUS_RESET_O), .PORT_OP_O(PORT_OP_O));
`default_nettype wire

// ===== tb_usb_host_port_compound_sequencer.sv
/* Self-checking bench for the compound sequencer: AHB-Lite master tasks,
   device model, error injection. Assumes shortened phase counts. */
`timescale 1ns/1ps
`default_nettype none
`include "hps_regs.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_usb_host_port_compound_sequencer;
  localparam RSTC = 12;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] err = 3'h0;
  logic plugged = 1'b0;
  logic hs = 1'b0;
  logic [31:0] rd;
  wire hready, hresp, attach, chirp, bus_rst, port_op, irq;
  wire [31:0] hrdata;
  wire [2:0] state;
  int checks = 0;
  int n_fail = 0;
  always #50 clk = ~clk;
  hps_sequencer #(.DIS_CYCLES(5), .RST_CYCLES(RSTC)) uut (.CLK_I(clk), .RST_I(rst),
    .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .HRDATA_O(hrdata), .ATTACH_I(attach), .CHIRP_OK_I(chirp), .CHIRP_NG_I(err[0]),
    .DISCONNECT_I(err[1]), .VBUS_ERR_I(err[2]), .STATE_O(state), .BUS_RESET_O(bus_rst),
    .PORT_OP_O(port_op), .IRQ_O(irq));
  hps_usb_device_model dev (.clk_i(clk), .rst_i(rst), .plugged_i(plugged),
    .high_speed_i(hs), .bus_reset_i(bus_rst), .attach_o(attach), .chirp_o(chirp));
  ////////////////////////////////////////
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    `CHK(rd, exp)
  endtask
  task automatic wait_st(input logic [2:0] s);
    int i;
    for (i = 0; i < 100 && state !== s; i++) @(posedge clk);
  endtask
  task automatic t_regs();
    xfer(8'h40, 1'b1, 32'hFFFFFFFF);
    `CHK(hresp, 1'b0)
    for (int i = 0; i < 6; i++) rd_chk((i == 5) ? 8'h40 : 8'(4 * i), 32'h0);
  endtask
  task automatic t_wait_dis();
    xfer(`HPS_OFS_CTRL, 1'b1, {28'h0, `HPS_CMD_WAIT_DIS});
    repeat (3) @(posedge clk);
    `CHK(state, `HPS_ST_WAIT)
    plugged <= 1'b1;
    wait_st(`HPS_ST_DIS);
    repeat (10) @(posedge clk);
    `CHK(state, `HPS_ST_DIS)
    xfer(`HPS_OFS_CTRL, 1'b0, 32'h0);
    `CHK(rd[10:0], 11'h205)
    rd_chk(`HPS_OFS_STAT0, 32'h1);
    rd_chk(`HPS_OFS_STAT1, 32'h1);
    rd_chk(`HPS_OFS_STAT1, 32'h0);
  endtask
  task automatic t_wait_op_hs();
    hs <= 1'b1;
    xfer(`HPS_OFS_MASK1, 1'b1, 32'h2);
    xfer(`HPS_OFS_CTRL, 1'b1, {28'h0, `HPS_CMD_WAIT_OP});
    wait_st(`HPS_ST_OP);
    `CHK(port_op, 1'b1)
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    rd_chk(`HPS_OFS_STAT0, 32'h3);
    rd_chk(`HPS_OFS_STAT1, 32'h3);
    @(posedge clk);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_rst_op_fs();
    int n;
    hs <= 1'b0;
    xfer(`HPS_OFS_MASK1, 1'b1, 32'h0);
    xfer(`HPS_OFS_CTRL, 1'b1, {28'h0, `HPS_CMD_RST_OP});
    wait_st(`HPS_ST_RST);
    for (n = 0; n < 50 && state === `HPS_ST_RST; n++) @(posedge clk);
    `CHK(n, RSTC + 1)
    `CHK(state, `HPS_ST_OP)
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    rd_chk(`HPS_OFS_STAT0, 32'h0);
    rd_chk(`HPS_OFS_STAT1, 32'h2);
  endtask
  task automatic t_aborts();
    hs <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (k == 3) plugged <= 1'b0;
      xfer(`HPS_OFS_CTRL, 1'b1, {28'h0, (k == 3) ? `HPS_CMD_WAIT : `HPS_CMD_RST_OP});
      wait_st((k == 3) ? `HPS_ST_WAIT : `HPS_ST_RST);
      err <= (k == 3) ? 3'h4 : 3'(1 << k);
      @(posedge clk);
      err <= 3'h0;
      @(posedge clk);
      `CHK(state, `HPS_ST_IDLE)
      rd_chk(`HPS_OFS_STAT0, (k == 3) ? 32'h10 : 32'h4 << k);
    end
  endtask
  // Plain commands, an unknown code, and wait-then-operational with a full-speed device
  task automatic t_plain();
    hs <= 1'b0;
    plugged <= 1'b0;
    xfer(`HPS_OFS_CTRL, 1'b1, {28'h0, `HPS_CMD_DIS});
    repeat (8) @(posedge clk);
    rd_chk(`HPS_OFS_CTRL, 32'h202);
    rd_chk(`HPS_OFS_STAT1, 32'h1);
    xfer(`HPS_OFS_CTRL, 1'b1, {28'h0, `HPS_CMD_RST});
    @(posedge clk);
    `CHK(bus_rst, 1'b1)
    repeat (14) @(posedge clk);
    `CHK(state, `HPS_ST_RST)
    `CHK(bus_rst, 1'b0)
    rd_chk(`HPS_OFS_STAT1, 32'h2);
    xfer(`HPS_OFS_CTRL, 1'b1, {28'h0, `HPS_CMD_OP});
    @(posedge clk);
    `CHK(port_op, 1'b1)
    xfer(`HPS_OFS_CTRL, 1'b1, 32'hF);
    rd_chk(`HPS_OFS_CTRL, 32'h40F);
    xfer(`HPS_OFS_MASK0, 1'b1, 32'h1);
    xfer(`HPS_OFS_CTRL, 1'b1, {28'h0, `HPS_CMD_WAIT_OP});
    rd_chk(`HPS_OFS_CTRL, 32'h1106);
    plugged <= 1'b1;
    wait_st(`HPS_ST_OP);
    `CHK(state, `HPS_ST_OP)
    `CHK(irq, 1'b1)
    rd_chk(`HPS_OFS_STAT0, 32'h1);
    rd_chk(`HPS_OFS_STAT1, 32'h3);
  endtask
  task automatic finish_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_wait_dis();
    t_wait_op_hs();
    t_rst_op_fs();
    t_aborts();
    t_plain();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule // tb_usb_host_port_compound_sequencer
`default_nettype wire
